// ===== dv/dcrm_panel_model.sv
`timescale 1ns/1ps
`default_nettype none

module dcrm_panel_model
  import dcrm_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        rst_n,     // Synchronous reset, active low
  input  wire dcrm_pad_t   pad_out,   // Device pad levels
  input  wire logic        pad_vd_oe, // Device drives data pads
  input  wire logic        send,      // Return one read word
  input  wire logic [31:0] word,      // Word to return
  output logic             rd_valid,  // Read word strobe
  output logic      [31:0] rd_data,   // Read word
  output logic      [23:0] pad_vd_in  // Resolved data pad level
);
  logic [23:0] churn;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      churn    <= 24'h000000;
      rd_valid <= 1'b0;
      rd_data  <= 32'h0000_0000;
    end
    else
    begin
      churn    <= churn + 24'h5A3C17;
      rd_valid <= send;
      // Outside the strobe the word keeps toggling so stale data never matches
      rd_data  <= send ? word : ~rd_data;
    end
  end

  // A released bus floats: show a moving pattern, not the last value
  assign pad_vd_in = pad_vd_oe ? pad_out.vd : churn;
endmodule

`default_nettype wire

// ===== dv/dcrm_regbank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module dcrm_regbank_tb_top import dcrm_pkg::*;;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        pad_vd_oe, pk_valid, send, rd_valid, err;
  logic [31:0] paddr, pwdata, prdata, cmd_tm, word, rd_data, rd;
  logic [23:0] pad_vd_in;
  logic [17:0] cmd_vd_in;
  logic [1:0]  intf_sel, disp_fmt;
  logic [2:0]  packing;
  dcrm_rgb_t   rgb;
  dcrm_cmd_t   cmd;
  dcrm_pad_t   pad_out;
  int          mismatches, comparisons;

  dcrm_regbank dut_u (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .IRQ(irq), .RGB_TIMING(rgb), .CMD_BUS(cmd),
    .CMD_RD_VALID(rd_valid), .CMD_RD_DATA(rd_data), .PAD_VD_IN(pad_vd_in),
    .PAD_OUT(pad_out), .PAD_VD_OE(pad_vd_oe), .CMD_VD_IN(cmd_vd_in),
    .INTF_SELECT(intf_sel), .PANEL_PACKING(packing), .PACKING_VALID(pk_valid),
    .DISPLAY_FORMAT(disp_fmt), .CMD_TIMING(cmd_tm));

  dcrm_panel_model panel_u (.clk(clock), .rst_n(reset_n), .pad_out(pad_out),
    .pad_vd_oe(pad_vd_oe), .send(send), .word(word), .rd_valid(rd_valid),
    .rd_data(rd_data), .pad_vd_in(pad_vd_in));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
    else
    begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  function automatic logic [31:0] pad_exp(input logic [1:0] s);
    if (s == 2'b00)
      return {3'h0, rgb.vclk, rgb.hsync, rgb.vsync, rgb.vden, rgb.lend, rgb.vd};
    if (s == 2'b01)
      return 32'h0000_0000;
    return {3'h0, cmd.wr, cmd.cs0, cmd.cs1, cmd.rs, cmd.oe, 6'h00, cmd.vd};
  endfunction

  initial
  begin
    logic [31:0] v;
    logic [31:0] pa [3];
    logic [1:0]  s;
    logic [2:0]  k;
    pa = '{OFF_PAL_BASE, OFF_PAL_BASE + 32'h0000_03FC, OFF_PAL_OVL + 32'h0000_001C};
    mismatches = 0;
    comparisons = 0;
    {reset_n, psel, penable, pwrite, send} = 5'h00;
    paddr  = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    word   = 32'hC3A5_0F96;
    rgb    = 29'h15A5_C3E1;
    cmd    = 24'hB35A_17;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < NREG; i++)
    begin
      apb(1'b0, REG_TABLE[i], 32'h0000_0000);
      chk("reset value", (i == int'(IDX_INT_CTRL)) ? RST_INT_CTRL : RST_ZERO, rd);
    end
    for (int i = 0; i < NREG - 2; i++)
    begin
      if (i == int'(IDX_CMD_RDATA))
        continue;
      v = 32'h5A00_00FF ^ (32'(i) * 32'h0101_0101);
      apb(1'b1, REG_TABLE[i], v);
      apb(1'b0, REG_TABLE[i], 32'h0000_0000);
      chk("rw", (i == 0) ? (v & MAIN_CTRL_WMASK) : v, rd);
    end
    apb(1'b1, OFF_CMD_RDATA, 32'hFFFF_FFFF);
    apb(1'b0, OFF_CMD_RDATA, 32'h0000_0000);
    chk("read only", 32'h0000_0000, rd);
    apb(1'b0, 32'h4C80_0C00, 32'h0000_0000);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    for (int j = 0; j < 3; j++)
      apb(1'b1, pa[j], 32'h6B00_0000 + 32'(j));
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b0, pa[j], 32'h0000_0000);
      chk("palette", 32'h6B00_0000 + 32'(j), rd);
    end
    apb(1'b1, OFF_CMD_MAIN_TM, 32'h1111_2222);
    apb(1'b1, OFF_CMD_SUB_TM, 32'h3333_4444);
    // Every select meets each packing code 0 to 4
    for (int i = 0; i < 20; i++)
    begin
      s = 2'(i % 4);
      k = 3'(i % 5);
      v = {8'hFF, s, k, 3'(4 - i % 5), 1'b1, s, 13'h1ABC};
      apb(1'b1, OFF_MAIN_CTRL, v);
      apb(1'b0, OFF_MAIN_CTRL, 32'h0000_0000);
      chk("main ctrl", v & MAIN_CTRL_WMASK, rd);
      chk("select", {30'h0, s}, {30'h0, intf_sel});
      chk("packing", (s == 2'b11) ? 32'(k) : (s == 2'b10) ? 32'(4 - i % 5) : 32'h0,
        {29'h0, packing});
      chk("packing valid", {31'h0, s[1]}, {31'h0, pk_valid});
      chk("format", {30'h0, s}, {30'h0, disp_fmt});
      chk("cmd timing", (s == 2'b10) ? 32'h1111_2222 : (s == 2'b11) ? 32'h3333_4444 :
        32'h0, cmd_tm);
      chk("pads", pad_exp(s), {3'h0, pad_out});
      chk("pad enable", {31'h0, (s == 2'b00) | (s[1] & cmd.vd_oe)}, {31'h0, pad_vd_oe});
      // Driven pads come back through the two-stage synchroniser
      if (s != 2'b01)
        chk("pad data in", {14'h0, (s == 2'b00) ? rgb.vd[17:0] : cmd.vd},
          {14'h0, cmd_vd_in});
    end
    apb(1'b1, OFF_IRQ_STATUS, IRQ_WMASK);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0004);
    apb(1'b1, OFF_CMD_RDATA, 32'h0000_0000);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
    chk("status ro write", 32'h0000_0004, rd);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, 32'h4C80_0002, 32'h0000_0000);
    apb(1'b1, OFF_IRQ_STATUS, 32'h0000_0004);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
    chk("status unmapped", 32'h0000_0008, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    @(posedge clock);
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0010);
    apb(1'b0, OFF_CMD_RDATA, 32'h0000_0000);
    chk("panel word", word, rd);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
    chk("status capture", 32'h0000_0018, rd);
    chk("irq capture", 32'h1, {31'h0, irq});
    stop_test();
  end
endmodule

`default_nettype wire

// ===== hw/dcrm_palette.sv
`timescale 1ns/1ps
`default_nettype none

module dcrm_palette
  import dcrm_pkg::*;
(
  input  wire logic        clk,    // System clock
  input  wire logic        we,     // Write strobe
  input  wire logic [7:0]  index,  // Entry index
  input  wire logic [31:0] wdata,  // Write word
  output logic      [31:0] rdata   // Entry at index
);

  typedef struct packed {
    logic [255:0][31:0] mem;
  } dcrm_pal_state_t;

  dcrm_pal_state_t s;
  dcrm_pal_state_t next_s;

  assign rdata = s.mem[index];

  always_comb
  begin
    next_s = s;
    if (we)
    begin
      next_s.mem[index] = wdata;
    end
  end

  // No reset: contents are undefined after reset, and skipping it saves 8K reset nets
  always_ff @(posedge clk)
  begin
    s <= next_s;
  end

endmodule

`default_nettype wire

// ===== hw/dcrm_pkg.sv
package dcrm_pkg;

  localparam int NREG = 42;

  // Register byte addresses
  localparam logic [31:0] OFF_MAIN_CTRL   = 32'h4C80_0000;
  localparam logic [31:0] OFF_SIG_CTRL    = 32'h4C80_0004;
  localparam logic [31:0] OFF_TIMING_A    = 32'h4C80_0008;
  localparam logic [31:0] OFF_TIMING_B    = 32'h4C80_000C;
  localparam logic [31:0] OFF_TIMING_C    = 32'h4C80_0010;
  localparam logic [31:0] OFF_BASE_WCTRL  = 32'h4C80_0014;
  localparam logic [31:0] OFF_OVL_WCTRL   = 32'h4C80_0018;
  localparam logic [31:0] OFF_BASE_POS_A  = 32'h4C80_0028;
  localparam logic [31:0] OFF_BASE_POS_B  = 32'h4C80_002C;
  localparam logic [31:0] OFF_OVL_POS_A   = 32'h4C80_0034;
  localparam logic [31:0] OFF_OVL_POS_B   = 32'h4C80_0038;
  localparam logic [31:0] OFF_OVL_ALPHA   = 32'h4C80_003C;
  localparam logic [31:0] OFF_B0_START    = 32'h4C80_0064;
  localparam logic [31:0] OFF_B1_START    = 32'h4C80_0068;
  localparam logic [31:0] OFF_OVL_START   = 32'h4C80_006C;
  localparam logic [31:0] OFF_B0_END      = 32'h4C80_007C;
  localparam logic [31:0] OFF_B1_END      = 32'h4C80_0080;
  localparam logic [31:0] OFF_OVL_END     = 32'h4C80_0084;
  localparam logic [31:0] OFF_B0_SIZE     = 32'h4C80_0094;
  localparam logic [31:0] OFF_B1_SIZE     = 32'h4C80_0098;
  localparam logic [31:0] OFF_OVL_SIZE    = 32'h4C80_009C;
  localparam logic [31:0] OFF_INT_CTRL    = 32'h4C80_00AC;
  localparam logic [31:0] OFF_KEY_CTRL1   = 32'h4C80_00B0;
  localparam logic [31:0] OFF_KEY_VAL1    = 32'h4C80_00B4;
  localparam logic [31:0] OFF_KEY_CTRL2   = 32'h4C80_00B8;
  localparam logic [31:0] OFF_KEY_VAL2    = 32'h4C80_00BC;
  localparam logic [31:0] OFF_KEY_CTRL3   = 32'h4C80_00C0;
  localparam logic [31:0] OFF_KEY_VAL3    = 32'h4C80_00C4;
  localparam logic [31:0] OFF_KEY_CTRL4   = 32'h4C80_00C8;
  localparam logic [31:0] OFF_KEY_VAL4    = 32'h4C80_00CC;
  localparam logic [31:0] OFF_BASE_FILL   = 32'h4C80_00D0;
  localparam logic [31:0] OFF_OVL_FILL    = 32'h4C80_00D4;
  localparam logic [31:0] OFF_PAL_CTRL    = 32'h4C80_00E4;
  localparam logic [31:0] OFF_CMD_MAIN_TM = 32'h4C80_0130;
  localparam logic [31:0] OFF_CMD_SUB_TM  = 32'h4C80_0134;
  localparam logic [31:0] OFF_DITHER      = 32'h4C80_0138;
  localparam logic [31:0] OFF_CMD_CMD     = 32'h4C80_013C;
  localparam logic [31:0] OFF_CMD_WDATA   = 32'h4C80_0140;
  localparam logic [31:0] OFF_CMD_RDATA   = 32'h4C80_0144;
  localparam logic [31:0] OFF_SOFT_TRIG   = 32'h4C80_0160;
  localparam logic [31:0] OFF_IRQ_STATUS  = 32'h4C80_01F0;
  localparam logic [31:0] OFF_IRQ_MASK    = 32'h4C80_01F4;
  localparam logic [31:0] OFF_PAL_BASE    = 32'h4C80_0400;
  localparam logic [31:0] OFF_PAL_OVL     = 32'h4C80_0800;

  localparam logic [31:0] REG_TABLE [NREG] = '{
    OFF_MAIN_CTRL, OFF_SIG_CTRL, OFF_TIMING_A, OFF_TIMING_B, OFF_TIMING_C,
    OFF_BASE_WCTRL, OFF_OVL_WCTRL, OFF_BASE_POS_A, OFF_BASE_POS_B,
    OFF_OVL_POS_A, OFF_OVL_POS_B, OFF_OVL_ALPHA,
    OFF_B0_START, OFF_B1_START, OFF_OVL_START, OFF_B0_END, OFF_B1_END,
    OFF_OVL_END, OFF_B0_SIZE, OFF_B1_SIZE, OFF_OVL_SIZE, OFF_INT_CTRL,
    OFF_KEY_CTRL1, OFF_KEY_VAL1, OFF_KEY_CTRL2, OFF_KEY_VAL2,
    OFF_KEY_CTRL3, OFF_KEY_VAL3, OFF_KEY_CTRL4, OFF_KEY_VAL4,
    OFF_BASE_FILL, OFF_OVL_FILL, OFF_PAL_CTRL, OFF_CMD_MAIN_TM,
    OFF_CMD_SUB_TM, OFF_DITHER, OFF_CMD_CMD, OFF_CMD_WDATA, OFF_CMD_RDATA,
    OFF_SOFT_TRIG, OFF_IRQ_STATUS, OFF_IRQ_MASK
  };

  // Table positions of registers with special behaviour
  localparam logic [5:0] IDX_MAIN_CTRL   = 6'h00;
  localparam logic [5:0] IDX_INT_CTRL    = 6'h15;
  localparam logic [5:0] IDX_CMD_MAIN_TM = 6'h21;
  localparam logic [5:0] IDX_CMD_SUB_TM  = 6'h22;
  localparam logic [5:0] IDX_CMD_RDATA   = 6'h26;
  localparam logic [5:0] IDX_IRQ_STATUS  = 6'h28;
  localparam logic [5:0] IDX_IRQ_MASK    = 6'h29;

  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam logic [31:0] RST_INT_CTRL = 32'h03F0_0000;

  localparam logic [31:0] MAIN_CTRL_WMASK = 32'h00FF_7FFF;
  localparam int          IFSEL_LSB       = 22;
  localparam int          SUBPK_LSB       = 19;
  localparam int          MAINPK_LSB      = 16;
  localparam int          FMT_LSB         = 13;
  localparam int          PAL_IDX_LSB     = 2;
  localparam int          PAL_HIT_LSB     = 10;

  localparam int          NEV          = 5;
  localparam int          EV_IF_CHANGE = 0;
  localparam int          EV_IF_RSVD   = 1;
  localparam int          EV_RO_WRITE  = 2;
  localparam int          EV_UNMAPPED  = 3;
  localparam int          EV_RD_DATA   = 4;
  localparam logic [31:0] IRQ_WMASK    = 32'h0000_001F;

  typedef enum logic [1:0] {
    DCRM_IF_RGB  = 2'b00,
    DCRM_IF_RSVD = 2'b01,
    DCRM_IF_MAIN = 2'b10,
    DCRM_IF_SUB  = 2'b11
  } dcrm_if_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } dcrm_apb_req_t;

  typedef struct packed {
    logic        vclk;
    logic        hsync;
    logic        vsync;
    logic        vden;
    logic        lend;
    logic [23:0] vd;
  } dcrm_rgb_t;

  typedef struct packed {
    logic        wr;
    logic        cs0;
    logic        cs1;
    logic        rs;
    logic        oe;
    logic [17:0] vd;
    logic        vd_oe;
  } dcrm_cmd_t;

  typedef struct packed {
    logic        clk_wr;
    logic        hsync_cs0;
    logic        vsync_cs1;
    logic        vden_rs;
    logic        lend_oe;
    logic [23:0] vd;
  } dcrm_pad_t;

  typedef struct packed {
    logic       hit;
    logic [5:0] idx;
  } dcrm_dec_t;

endpackage

// ===== hw/dcrm_regbank.sv
// Functional notes
// RULE1: bits 23:22 select RGB, main or sub interface
// RULE2: sub packing bits 21:19 only when select=11
// RULE3: main packing bits 18:16 only when select=10
// RULE4: RGB mode: bits 14:13 choose order/serial
// RULE5: command-bus mode: format code 00 parallel RGB
// RULE6: each window has 256-word palette, unreset
// RULE7: all zero reset except interrupt control
// RULE8: base window two buffer sets, overlay one
// RULE9: command read-data register is read-only
// RULE10: main/sub timing registers apply per panel
// RULE11: each key set: control plus value register
// RULE12: pads carry RGB, command bus or nothing
// RULE13: aligned words; reserved bits read zero
`timescale 1ns/1ps
`default_nettype none

module dcrm_regbank
  import dcrm_pkg::*;
(
  input  wire logic          CLOCK,          // 200 MHz system clock
  input  wire logic          RESET_N,        // Synchronous reset, active low
  input  wire logic          PSEL,           // APB select
  input  wire logic          PENABLE,        // APB access phase
  input  wire logic          PWRITE,         // APB direction
  input  wire logic [31:0]   PADDR,          // APB byte address
  input  wire logic [31:0]   PWDATA,         // APB write data
  output logic               PREADY,         // APB ready
  output logic      [31:0]   PRDATA,         // APB read data
  output logic               PSLVERR,        // APB error on unmapped address
  output logic               IRQ,            // Level interrupt
  input  wire dcrm_rgb_t     RGB_TIMING,     // Timing generator outputs
  input  wire dcrm_cmd_t     CMD_BUS,        // Command-bus engine outputs
  input  wire logic          CMD_RD_VALID,   // Panel read word strobe
  input  wire logic [31:0]   CMD_RD_DATA,    // Panel read word
  input  wire logic [23:0]   PAD_VD_IN,      // Data pad input level
  output dcrm_pad_t          PAD_OUT,        // Shared pad output levels
  output logic               PAD_VD_OE,      // Data pad output enable
  output logic      [17:0]   CMD_VD_IN,      // Synchronised panel data
  output logic      [1:0]    INTF_SELECT,    // Active panel interface
  output logic      [2:0]    PANEL_PACKING,  // Packing of active command panel
  output logic               PACKING_VALID,  // A command panel is selected
  output logic      [1:0]    DISPLAY_FORMAT, // Order or serial mode
  output logic      [31:0]   CMD_TIMING      // Timing word of active panel
);

  typedef struct packed {
    logic [NREG-1:0][31:0] regs;
    logic                  ready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  irq;
    dcrm_pad_t             pad;
    logic                  pad_vd_oe;
    logic [17:0]           vd_sync1;
    logic [17:0]           vd_sync2;
    logic [1:0]            if_sel;
    logic [2:0]            packing;
    logic                  pack_valid;
    logic [1:0]            fmt;
    logic [31:0]           timing;
  } dcrm_state_t;

  dcrm_state_t   s;
  dcrm_state_t   next_s;
  dcrm_apb_req_t req;
  dcrm_dec_t     dec;
  logic          pal0_hit;
  logic          pal1_hit;
  logic          pal0_we;
  logic          pal1_we;
  logic [31:0]   pal0_rdata;
  logic [31:0]   pal1_rdata;
  logic          access;
  logic          done;

  function automatic dcrm_dec_t reg_decode(input logic [31:0] addr);
    dcrm_dec_t d;
    d = '0;
    for (int i = 0; i < NREG; i++)
    begin
      if (addr == REG_TABLE[i])
      begin
        d.hit = 1'b1;
        d.idx = 6'(i);
      end
    end
    return d;
  endfunction

  function automatic logic pal_hit(input logic [31:0] addr, input logic [31:0] base);
    return (addr[31:PAL_HIT_LSB] == base[31:PAL_HIT_LSB]) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] write_mask(input logic [5:0] idx);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    if (idx == IDX_MAIN_CTRL)
    begin
      m = MAIN_CTRL_WMASK;
    end
    else if (idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK)
    begin
      m = IRQ_WMASK;
    end
    return m;
  endfunction

  assign req      = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};
  assign dec      = reg_decode(req.paddr);
  assign pal0_hit = pal_hit(req.paddr, OFF_PAL_BASE);
  assign pal1_hit = pal_hit(req.paddr, OFF_PAL_OVL);
  assign access   = req.psel & req.penable;
  assign done     = access & s.ready;
  assign pal0_we  = done & req.pwrite & pal0_hit;
  assign pal1_we  = done & req.pwrite & pal1_hit;

  // One palette per window, each reached word by word
  dcrm_palette u_base_palette (  // [RULE6]
    .clk   (CLOCK),
    .we    (pal0_we),
    .index (req.paddr[PAL_IDX_LSB +: 8]),
    .wdata (req.pwdata),
    .rdata (pal0_rdata)
  );

  dcrm_palette u_overlay_palette (  // [RULE6]
    .clk   (CLOCK),
    .we    (pal1_we),
    .index (req.paddr[PAL_IDX_LSB +: 8]),
    .wdata (req.pwdata),
    .rdata (pal1_rdata)
  );

  always_comb
  begin
    logic [NEV-1:0] ev;
    logic [31:0]    ctrl;
    logic [1:0]     new_sel;
    ev      = '0;
    ctrl    = '0;
    new_sel = '0;
    next_s  = s;

    // One wait state keeps PREADY and PRDATA straight off flip-flops
    next_s.ready = access & ~s.ready;
    if (access && !s.ready)
    begin
      next_s.pslverr = ~(dec.hit | pal0_hit | pal1_hit);
      next_s.prdata  = '0;
      if (!req.pwrite)
      begin
        if (dec.hit)
        begin
          next_s.prdata = s.regs[dec.idx];  // [RULE13]
        end
        else if (pal0_hit)
        begin
          next_s.prdata = pal0_rdata;
        end
        else if (pal1_hit)
        begin
          next_s.prdata = pal1_rdata;
        end
      end
    end

    // Buffer, key and fill registers are plain words of the table [RULE8] [RULE11]
    if (done && req.pwrite && dec.hit)
    begin
      if (dec.idx == IDX_CMD_RDATA)
      begin
        ev[EV_RO_WRITE] = 1'b1;  // [RULE9]
      end
      else if (dec.idx == IDX_IRQ_STATUS)
      begin
        next_s.regs[IDX_IRQ_STATUS] = s.regs[IDX_IRQ_STATUS] & ~(req.pwdata & IRQ_WMASK);
      end
      else
      begin
        next_s.regs[dec.idx] = req.pwdata & write_mask(dec.idx);  // [RULE13]
      end
      if (dec.idx == IDX_MAIN_CTRL)
      begin
        new_sel = req.pwdata[IFSEL_LSB +: 2];
        ev[EV_IF_CHANGE] = (new_sel != s.regs[IDX_MAIN_CTRL][IFSEL_LSB +: 2]);
        ev[EV_IF_RSVD]   = (new_sel == DCRM_IF_RSVD);
      end
    end
    if (done && !(dec.hit || pal0_hit || pal1_hit))
    begin
      ev[EV_UNMAPPED] = 1'b1;
    end

    if (CMD_RD_VALID)
    begin
      next_s.regs[IDX_CMD_RDATA] = CMD_RD_DATA;  // [RULE9]
      ev[EV_RD_DATA] = 1'b1;
    end

    // A new event wins over a clear in the same cycle
    next_s.regs[IDX_IRQ_STATUS][NEV-1:0] = next_s.regs[IDX_IRQ_STATUS][NEV-1:0] | ev;
    next_s.irq = |(next_s.regs[IDX_IRQ_STATUS][NEV-1:0] & next_s.regs[IDX_IRQ_MASK][NEV-1:0]);

    // Decoded mode outputs follow the control word written this cycle
    ctrl              = next_s.regs[IDX_MAIN_CTRL];
    next_s.if_sel     = ctrl[IFSEL_LSB +: 2];  // [RULE1]
    next_s.fmt        = ctrl[FMT_LSB +: 2];  // [RULE4] [RULE5]
    next_s.packing    = '0;
    next_s.pack_valid = 1'b0;
    next_s.timing     = '0;
    unique case (dcrm_if_t'(ctrl[IFSEL_LSB +: 2]))
      DCRM_IF_SUB:
      begin
        next_s.packing    = ctrl[SUBPK_LSB +: 3];  // [RULE2]
        next_s.pack_valid = 1'b1;
        next_s.timing     = next_s.regs[IDX_CMD_SUB_TM];  // [RULE10]
      end
      DCRM_IF_MAIN:
      begin
        next_s.packing    = ctrl[MAINPK_LSB +: 3];  // [RULE3]
        next_s.pack_valid = 1'b1;
        next_s.timing     = next_s.regs[IDX_CMD_MAIN_TM];  // [RULE10]
      end
      DCRM_IF_RGB, DCRM_IF_RSVD:
      begin
        next_s.packing = '0;
      end
    endcase

    // Pad sharing follows the interface currently in force
    next_s.pad       = '0;
    next_s.pad_vd_oe = 1'b0;
    unique case (dcrm_if_t'(s.if_sel))
      DCRM_IF_RGB:
      begin
        next_s.pad       = '{clk_wr: RGB_TIMING.vclk, hsync_cs0: RGB_TIMING.hsync,
                             vsync_cs1: RGB_TIMING.vsync, vden_rs: RGB_TIMING.vden,
                             lend_oe: RGB_TIMING.lend, vd: RGB_TIMING.vd};  // [RULE12]
        next_s.pad_vd_oe = 1'b1;
      end
      DCRM_IF_MAIN, DCRM_IF_SUB:
      begin
        next_s.pad       = '{clk_wr: CMD_BUS.wr, hsync_cs0: CMD_BUS.cs0,
                             vsync_cs1: CMD_BUS.cs1, vden_rs: CMD_BUS.rs,
                             lend_oe: CMD_BUS.oe, vd: {6'h00, CMD_BUS.vd}};  // [RULE12]
        next_s.pad_vd_oe = CMD_BUS.vd_oe;
      end
      DCRM_IF_RSVD:
      begin
        next_s.pad = '0;  // [RULE12]
      end
    endcase

    next_s.vd_sync1 = PAD_VD_IN[17:0];
    next_s.vd_sync2 = s.vd_sync1;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      s <= '0;  // [RULE7]
      s.regs[IDX_INT_CTRL] <= RST_INT_CTRL;  // [RULE7]
    end
    else
    begin
      s <= next_s;
    end
  end

  assign PREADY         = s.ready;
  assign PRDATA         = s.prdata;
  assign PSLVERR        = s.pslverr;
  assign IRQ            = s.irq;
  assign PAD_OUT        = s.pad;
  assign PAD_VD_OE      = s.pad_vd_oe;
  assign CMD_VD_IN      = s.vd_sync2;
  assign INTF_SELECT    = s.if_sel;
  assign PANEL_PACKING  = s.packing;
  assign PACKING_VALID  = s.pack_valid;
  assign DISPLAY_FORMAT = s.fmt;
  assign CMD_TIMING     = s.timing;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  sequence ctrl_write_s;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFF_MAIN_CTRL;
  endsequence

  sequence ro_write_s;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFF_CMD_RDATA && !CMD_RD_VALID;
  endsequence

  ifsel_update_a: assert property (ctrl_write_s |=> INTF_SELECT == $past(PWDATA[IFSEL_LSB +: 2])) // [RULE1]
    else $error("interface select did not follow control write");

  sub_packing_a: assert property (INTF_SELECT == DCRM_IF_SUB |->
    PACKING_VALID && PANEL_PACKING == s.regs[IDX_MAIN_CTRL][SUBPK_LSB +: 3]) // [RULE2]
    else $error("sub panel packing not applied");

  main_packing_a: assert property (ctrl_write_s ##1 INTF_SELECT == DCRM_IF_MAIN |->
    PANEL_PACKING == $past(PWDATA[MAINPK_LSB +: 3])) // [RULE3]
    else $error("main panel packing not applied");

  rgb_format_a: assert property (INTF_SELECT == DCRM_IF_RGB |->
    !PACKING_VALID && DISPLAY_FORMAT == s.regs[IDX_MAIN_CTRL][FMT_LSB +: 2]) // [RULE4]
    else $error("rgb format field not presented");

  cmd_format_a: assert property (INTF_SELECT[1] |->
    DISPLAY_FORMAT == s.regs[IDX_MAIN_CTRL][FMT_LSB +: 2]) // [RULE5]
    else $error("command bus format field not presented");

  intctrl_reset_a: assert property ($rose(RESET_N) |->
    s.regs[IDX_INT_CTRL] == RST_INT_CTRL && s.regs[IDX_MAIN_CTRL] == RST_ZERO) // [RULE7]
    else $error("reset value wrong after reset");

  ro_protect_a: assert property (ro_write_s |=> $stable(s.regs[IDX_CMD_RDATA]) ##1
    s.regs[IDX_IRQ_STATUS][EV_RO_WRITE]) // [RULE9]
    else $error("read-only register written or event lost");

  timing_select_a: assert property (INTF_SELECT == DCRM_IF_SUB ##1 INTF_SELECT == DCRM_IF_SUB |->
    CMD_TIMING == s.regs[IDX_CMD_SUB_TM]) // [RULE10]
    else $error("sub timing register not steered to output");

  pad_reserved_a: assert property (INTF_SELECT == DCRM_IF_RSVD |=> PAD_OUT == '0 && !PAD_VD_OE) // [RULE12]
    else $error("pads driven in reserved interface mode");

  reserved_bits_a: assert property (PREADY && !PWRITE && PADDR == OFF_MAIN_CTRL |->
    PRDATA[31:24] == 8'h00 && !PRDATA[15]) // [RULE13]
    else $error("reserved control bits read non-zero");

  apb_answer_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("apb answer later than one wait state");

endmodule

`default_nettype wire
